// file: hw/sccc_channel.sv
// serial channel control: clock pin options, mode, sync pattern, parameter area
// ----------------------------------------
// Summary of operation
// [RULE1] rx clock pin driven unless tristate bit; code drives it only while rx_clk_from_baud is also set
// [RULE2] tx clock pin driven unless tristate bit; code drives it only while tx_clk_from_baud is also set
// [RULE3] prescaler bit inserts timer input halving
// [RULE4] clock pin options 16 bits, reset zero
// [RULE5] diagnostic field selects normal/loop/echo/software
// [RULE6] receive enable; clearing discards receive data
// [RULE7] clearing receive enable aborts current character
// [RULE8] enables act without serial clocks present
// [RULE9] software issues hunt before re-enabling receiver
// [RULE10] clearing transmit enable aborts, idles line high
// [RULE11] protocol field: hdlc, uart, reserved, sync
// [RULE12] channel mode 16 bits, reset zero
// [RULE13] sync pattern resets to two flags
// [RULE14] sync bytes: second high, first low
// [RULE15] in uart sync register sets stop fraction
// [RULE16] software programs sync before bisync enable
// [RULE17] two descriptor tables per channel
// [RULE18] software writes full descriptor buffer pointers
// [RULE19] parameter area 80..BF above channel base
// [RULE20] common layout to 9A, protocol area after
// [RULE21] function codes at 80,81, length at 82
// [RULE22] unused option bits read zero
// [RULE23] separate halving for system clock source
// ----------------------------------------
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module sccc_channel
  import sccc_pkg::*;
#(
  parameter int PRM_WORDS = 32,
  parameter logic [11:0] CH_BASE = SCCC_CH0_BASE
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [11:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // clock sources
  input wire logic timer_input_one,
  input wire logic sys_clk_tick,
  input wire logic rx_clk_from_baud,
  input wire logic tx_clk_from_baud,
  input wire logic baud_clk,
  // clock pins
  output logic rx_clock_pin_one_o,
  output logic rx_clock_pin_one_oe,
  output logic tx_clock_pin_one_o,
  output logic tx_clock_pin_one_oe,
  // baud generator prescaler input ticks
  output logic baud_prescale_tick,
  // serial line
  input wire logic rx_bit_tick,
  input wire logic rx_data,
  input wire logic tx_bit_tick,
  output logic tx_data,
  // channel control to protocol engines
  output logic [1:0] diagnostic_field,
  output logic [1:0] protocol_field,
  output logic receive_enable,
  output logic transmit_enable,
  output logic hunt_active,
  output logic [7:0] first_sync_byte,
  output logic [7:0] second_sync_byte,
  output logic [15:0] stop_fraction_cfg,
  output logic [7:0] rx_char,
  output logic rx_char_valid
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic is_adr(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction : is_adr

  function automatic logic in_prm(input logic [11:0] a);
    return (a >= CH_BASE + SCCC_PRM_LO) && (a <= CH_BASE + SCCC_PRM_HI);
  endfunction : in_prm

  logic [15:0] cpo_q;
  logic [15:0] mode_q;
  logic [15:0] sync_q;
  logic sys_div_q;
  logic [15:0] prm_q [PRM_WORDS]; // RULE17
  logic [15:0] rx_drop_cnt_q;
  logic [15:0] tx_abort_cnt_q;
  logic hunt_q;
  logic [7:0] rx_sh_q;
  logic [3:0] rx_cnt_q;
  logic [7:0] rx_char_q;
  logic rx_valid_q;
  logic [7:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic tx_data_q;
  logic [7:0] tx_hold_q;
  logic tx_hold_full_q;
  logic [15:0] rdata_q;
  logic tin_tick;
  logic sys_tick;
  logic rx_en_now;
  logic tx_en_now;
  logic [4:0] prm_idx;

  assign rx_en_now = mode_q[SCCC_BIT_RXEN];
  assign tx_en_now = mode_q[SCCC_BIT_TXEN];
  assign prm_idx = 5'((addr - (CH_BASE + SCCC_PRM_LO)) >> 1);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpo_q <= SCCC_ZERO16; // RULE4
    end else if (ce && wr && is_adr(addr, SCCC_ADR_CLOCK_PIN_OPTIONS)) begin
      cpo_q <= wdata & SCCC_CPO_MASK; // RULE22
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= SCCC_ZERO16; // RULE12
    end else if (ce && wr && is_adr(addr, SCCC_ADR_CHANNEL_MODE)) begin
      mode_q <= wdata; // RULE8
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_q <= SCCC_SYNC_RESET; // RULE13
    end else if (ce && wr && is_adr(addr, SCCC_ADR_SYNC_PATTERN)) begin
      sync_q <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_div_q <= 1'b0;
    end else if (ce && wr && is_adr(addr, SCCC_ADR_SYS_DIV)) begin
      sys_div_q <= wdata[0]; // RULE23
    end
  end

  // parameter area: byte lanes at 80/81, word at 82 and beyond
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PRM_WORDS; i++) begin
        prm_q[i] <= SCCC_ZERO16;
      end
    end else if (ce && wr && in_prm(addr)) begin
      if (is_adr(addr, CH_BASE + SCCC_OFS_RX_FC)) begin
        prm_q[prm_idx][15:8] <= wdata[7:0]; // RULE21
      end else if (is_adr(addr, CH_BASE + SCCC_OFS_TX_FC)) begin
        prm_q[prm_idx][7:0] <= wdata[7:0]; // RULE21
      end else begin
        prm_q[prm_idx] <= wdata; // RULE19 RULE20
      end
    end
  end

  // hunt request: set by command, cleared once receiver enabled sees a char
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hunt_q <= 1'b0;
    end else if (ce) begin
      if (wr && is_adr(addr, SCCC_ADR_HUNT)) begin
        hunt_q <= 1'b1; // RULE9
      end else if (rx_valid_q) begin
        hunt_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // clock sources and pins
  // ----------------------------------------
  sccc_div2 u_tin_div (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .enable(cpo_q[SCCC_BIT_PDIV]),
    .tick_in(timer_input_one),
    .tick_out(tin_tick)
  ); // RULE3

  logic sys_phase_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_phase_q <= 1'b0;
    end else if (ce && sys_clk_tick) begin
      sys_phase_q <= sys_div_q ? ~sys_phase_q : 1'b0;
    end
  end
  assign sys_tick = sys_div_q ? (sys_clk_tick && sys_phase_q) : sys_clk_tick; // RULE23

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_prescale_tick <= 1'b0;
    end else if (ce) begin
      baud_prescale_tick <= tin_tick | sys_tick;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_clock_pin_one_o <= 1'b0;
      rx_clock_pin_one_oe <= 1'b0;
      tx_clock_pin_one_o <= 1'b0;
      tx_clock_pin_one_oe <= 1'b0;
    end else if (ce) begin
      rx_clock_pin_one_o <= baud_clk;
      rx_clock_pin_one_oe <= rx_clk_from_baud && !cpo_q[SCCC_BIT_RX_TRI]; // RULE1
      tx_clock_pin_one_o <= baud_clk;
      tx_clock_pin_one_oe <= tx_clk_from_baud && !cpo_q[SCCC_BIT_TX_TRI]; // RULE2
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic rx_in;
  always_comb begin
    unique case (sccc_diag_t'(mode_q[SCCC_DIAG_HI:SCCC_DIAG_LO]))
      SCCC_DIAG_LOOPBACK: rx_in = tx_data_q; // RULE5
      default: rx_in = rx_data;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sh_q <= 8'h00;
      rx_cnt_q <= 4'h0;
      rx_char_q <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_drop_cnt_q <= SCCC_ZERO16;
    end else if (ce) begin
      rx_valid_q <= 1'b0;
      if (!rx_en_now) begin
        if (rx_cnt_q != 4'h0) begin
          rx_drop_cnt_q <= rx_drop_cnt_q + SCCC_CNT_ONE; // RULE7
        end
        rx_cnt_q <= 4'h0; // RULE6 RULE7
        rx_sh_q <= 8'h00;
      end else if (rx_bit_tick) begin
        rx_sh_q <= {rx_in, rx_sh_q[7:1]};
        if (rx_cnt_q == 4'(SCCC_CHAR_BITS - 1)) begin
          rx_cnt_q <= 4'h0;
          rx_char_q <= {rx_in, rx_sh_q[7:1]};
          rx_valid_q <= 1'b1;
        end else begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // transmitter: echo takes received bits, else holding byte
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_sh_q <= 8'h00;
      tx_cnt_q <= 4'h0;
      tx_data_q <= 1'b1;
      tx_hold_q <= 8'h00;
      tx_hold_full_q <= 1'b0;
      tx_abort_cnt_q <= SCCC_ZERO16;
    end else if (ce) begin
      if (!tx_en_now) begin
        if (tx_cnt_q != 4'h0 || tx_hold_full_q) begin
          tx_abort_cnt_q <= tx_abort_cnt_q + SCCC_CNT_ONE;
        end
        tx_cnt_q <= 4'h0; // RULE10
        tx_hold_full_q <= 1'b0;
        tx_sh_q <= 8'h00;
        tx_data_q <= 1'b1;
      end else begin
        if (wr && is_adr(addr, SCCC_ADR_STATUS) && !tx_hold_full_q) begin
          tx_hold_q <= wdata[7:0];
          tx_hold_full_q <= 1'b1;
        end
        if (tx_bit_tick) begin
          if (mode_q[SCCC_DIAG_HI:SCCC_DIAG_LO] == SCCC_DIAG_ECHO) begin
            tx_data_q <= rx_data; // RULE5
          end else if (tx_cnt_q != 4'h0) begin
            tx_data_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[7:1]};
            tx_cnt_q <= tx_cnt_q - 4'h1;
          end else if (tx_hold_full_q) begin
            tx_data_q <= tx_hold_q[0];
            tx_sh_q <= {1'b1, tx_hold_q[7:1]};
            tx_cnt_q <= 4'(SCCC_CHAR_BITS - 1);
            tx_hold_full_q <= 1'b0;
          end else begin
            tx_data_q <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // read data and control outputs
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= SCCC_ZERO16;
    end else if (ce) begin
      rdata_q <= SCCC_ZERO16;
      if (rd) begin
        if (is_adr(addr, SCCC_ADR_CLOCK_PIN_OPTIONS)) begin
          rdata_q <= cpo_q; // RULE22
        end else if (is_adr(addr, SCCC_ADR_CHANNEL_MODE)) begin
          rdata_q <= mode_q;
        end else if (is_adr(addr, SCCC_ADR_SYNC_PATTERN)) begin
          rdata_q <= sync_q;
        end else if (is_adr(addr, SCCC_ADR_SYS_DIV)) begin
          rdata_q <= {15'h0000, sys_div_q};
        end else if (is_adr(addr, SCCC_ADR_STATUS)) begin
          rdata_q <= {rx_drop_cnt_q[5:0], tx_abort_cnt_q[5:0], hunt_q,
                      tx_hold_full_q, rx_cnt_q != 4'h0, tx_cnt_q != 4'h0};
        end else if (in_prm(addr)) begin
          if (is_adr(addr, CH_BASE + SCCC_OFS_RX_FC)) begin
            rdata_q <= {8'h00, prm_q[prm_idx][15:8]};
          end else if (is_adr(addr, CH_BASE + SCCC_OFS_TX_FC)) begin
            rdata_q <= {8'h00, prm_q[prm_idx][7:0]};
          end else begin
            rdata_q <= prm_q[prm_idx];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      diagnostic_field <= SCCC_DIAG_NORMAL;
      protocol_field <= SCCC_PROT_HDLC;
      receive_enable <= 1'b0;
      transmit_enable <= 1'b0;
      first_sync_byte <= SCCC_SYNC_RESET[7:0];
      second_sync_byte <= SCCC_SYNC_RESET[15:8];
      stop_fraction_cfg <= SCCC_ZERO16;
    end else if (ce) begin
      diagnostic_field <= mode_q[SCCC_DIAG_HI:SCCC_DIAG_LO]; // RULE5
      protocol_field <= mode_q[SCCC_PROT_HI:SCCC_PROT_LO]; // RULE11
      receive_enable <= rx_en_now; // RULE6
      transmit_enable <= tx_en_now;
      if (mode_q[SCCC_PROT_HI:SCCC_PROT_LO] == SCCC_PROT_UART) begin
        stop_fraction_cfg <= sync_q; // RULE15
      end else begin
        first_sync_byte <= sync_q[7:0]; // RULE14
        second_sync_byte <= sync_q[15:8]; // RULE14
        stop_fraction_cfg <= SCCC_ZERO16;
      end
    end
  end

  assign rdata = rdata_q;
  assign tx_data = tx_data_q;
  assign rx_char = rx_char_q;
  assign rx_char_valid = rx_valid_q;
  assign hunt_active = hunt_q;
endmodule : sccc_channel

// file: hw/sccc_pkg.sv
// package: register map, field layout and reset values of the serial channel control block
package sccc_pkg;
  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [11:0] SCCC_CH0_BASE = 12'h400;
  localparam logic [11:0] SCCC_CH1_BASE = 12'h500;
  localparam logic [11:0] SCCC_PRM_LO = 12'h080;
  localparam logic [11:0] SCCC_PRM_HI = 12'h0BF;
  localparam logic [11:0] SCCC_PRM_COMMON_HI = 12'h09B;
  localparam logic [11:0] SCCC_OFS_RX_FC = 12'h080;
  localparam logic [11:0] SCCC_OFS_TX_FC = 12'h081;
  localparam logic [11:0] SCCC_OFS_MRBL = 12'h082;
  localparam logic [11:0] SCCC_ADR_CLOCK_PIN_OPTIONS = 12'h8EE;
  localparam logic [11:0] SCCC_ADR_CHANNEL_MODE = 12'h8F0;
  localparam logic [11:0] SCCC_ADR_SYNC_PATTERN = 12'h8F2;
  localparam logic [11:0] SCCC_ADR_STATUS = 12'h8F4;
  localparam logic [11:0] SCCC_ADR_SYS_DIV = 12'h8F6;
  localparam logic [11:0] SCCC_ADR_HUNT = 12'h8F8;
  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int SCCC_BIT_TX_TRI = 15;
  localparam int SCCC_BIT_RX_TRI = 14;
  localparam int SCCC_BIT_PDIV = 12;
  localparam logic [15:0] SCCC_CPO_MASK = 16'hD000;
  localparam int SCCC_BIT_RXEN = 3;
  localparam int SCCC_BIT_TXEN = 2;
  localparam int SCCC_DIAG_HI = 5;
  localparam int SCCC_DIAG_LO = 4;
  localparam int SCCC_PROT_HI = 1;
  localparam int SCCC_PROT_LO = 0;
  localparam logic [15:0] SCCC_ZERO16 = 16'h0000;
  localparam logic [15:0] SCCC_SYNC_RESET = 16'h7E7E;
  localparam logic [15:0] SCCC_CNT_ONE = 16'h0001;
  typedef enum logic [1:0] {
    SCCC_DIAG_NORMAL = 2'h0,
    SCCC_DIAG_LOOPBACK = 2'h1,
    SCCC_DIAG_ECHO = 2'h2,
    SCCC_DIAG_SOFTWARE = 2'h3
  } sccc_diag_t;
  typedef enum logic [1:0] {
    SCCC_PROT_HDLC = 2'h0,
    SCCC_PROT_UART = 2'h1,
    SCCC_PROT_RSVD = 2'h2,
    SCCC_PROT_SYNC = 2'h3
  } sccc_prot_t;
  localparam int SCCC_CHAR_BITS = 8;
endpackage : sccc_pkg

// file: hw/sccc_div2.sv
// divide-by-two stage with bypass, run as a clock-enable pulse generator
`timescale 1ns/10ps
module sccc_div2
  import sccc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // source tick in, tick out
  input wire logic enable,
  input wire logic tick_in,
  output logic tick_out
);
  logic phase_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= 1'b0;
    end else if (ce && tick_in && enable) begin
      phase_q <= ~phase_q;
    end else if (ce && !enable) begin
      phase_q <= 1'b0;
    end
  end

  always_comb begin
    tick_out = enable ? (tick_in && phase_q) : tick_in;
  end
endmodule : sccc_div2

// file: test/sccc_channel_props.sv
// checker: port-level relations of the serial channel control block
`timescale 1ns/10ps
module sccc_channel_props
  import sccc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [11:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // clock sources and pins
  input wire logic rx_clk_from_baud,
  input wire logic tx_clk_from_baud,
  input wire logic baud_clk,
  input wire logic rx_clock_pin_one_o,
  input wire logic rx_clock_pin_one_oe,
  input wire logic tx_clock_pin_one_o,
  input wire logic tx_clock_pin_one_oe,
  // serial line and control
  input wire logic tx_data,
  input wire logic [1:0] diagnostic_field,
  input wire logic [1:0] protocol_field,
  input wire logic receive_enable,
  input wire logic transmit_enable,
  input wire logic [15:0] stop_fraction_cfg,
  input wire logic rx_char_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic mode_wr;
  assign mode_wr = wr && ce && (addr == SCCC_ADR_CHANNEL_MODE);
  a_rx_pin_off: assert property ($past(ce) && !$past(rx_clk_from_baud) |-> !rx_clock_pin_one_oe)
    else $error("rx clock pin driven without baud source");
  a_rx_pin_follow: assert property ($past(ce) && rx_clock_pin_one_oe |->
    rx_clock_pin_one_o == $past(baud_clk))
    else $error("rx clock pin does not follow baud clock");
  a_tx_pin_follow: assert property ($past(ce) && tx_clock_pin_one_oe |->
    tx_clock_pin_one_o == $past(baud_clk))
    else $error("tx clock pin does not follow baud clock");
  a_tx_pin_off: assert property ($past(ce) && !$past(tx_clk_from_baud) |-> !tx_clock_pin_one_oe)
    else $error("tx clock pin driven without baud source");
  a_rdata_idle: assert property ($past(ce) && !$past(rd) |-> rdata == SCCC_ZERO16)
    else $error("read data not zero outside read answer");
  a_cpo_unused: assert property ($past(rd && ce && addr == SCCC_ADR_CLOCK_PIN_OPTIONS)
    |-> (rdata & ~SCCC_CPO_MASK) == SCCC_ZERO16)
    else $error("unused option bits read nonzero");
  a_mode_lag: assert property ($past(mode_wr, 2) && !$past(mode_wr) |->
    receive_enable == $past(wdata[SCCC_BIT_RXEN], 2) && protocol_field == $past(wdata[1:0], 2)
    && diagnostic_field == $past(wdata[5:4], 2))
    else $error("mode outputs do not follow mode write");
  a_tx_idle: assert property (!transmit_enable |-> tx_data)
    else $error("tx line not idle while transmitter disabled");
  a_stop_frac: assert property ((protocol_field != SCCC_PROT_UART) [*3] |->
    stop_fraction_cfg == SCCC_ZERO16)
    else $error("stop fraction set outside uart");
  a_rx_off: assert property ((!receive_enable) [*3] |-> !rx_char_valid)
    else $error("character delivered while receiver disabled");
endmodule : sccc_channel_props
bind sccc_channel sccc_channel_props u_props (.clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata,
  .rx_clk_from_baud, .tx_clk_from_baud, .baud_clk, .rx_clock_pin_one_o, .rx_clock_pin_one_oe,
  .tx_clock_pin_one_o, .tx_clock_pin_one_oe, .tx_data, .diagnostic_field, .protocol_field,
  .receive_enable, .transmit_enable, .stop_fraction_cfg, .rx_char_valid);

// file: test/sccc_line_peer.sv
// serial line peer: sends receive bits with ticks, runs the transmit bit clock
`timescale 1ns/10ps
module sccc_line_peer (
  // clock
  input wire logic clk,
  // toward the channel
  output logic rx_bit_tick,
  output logic rx_data,
  output logic tx_bit_tick,
  output logic baud_clk
);
  int unsigned div = 0;
  logic tx_run = 1'b0;
  initial begin
    rx_bit_tick = 1'b0;
    rx_data = 1'b1;
    tx_bit_tick = 1'b0;
    baud_clk = 1'b0;
  end
  // transmit ticks only while the bench runs a transmission
  always @(posedge clk) begin
    baud_clk <= ~baud_clk;
    div <= (div == 3) ? 0 : div + 1;
    tx_bit_tick <= tx_run && (div == 3);
  end
  // least significant bit first, period cycles per bit
  task automatic send_bits(input logic [7:0] ch, input int nbits, input int period);
    for (int i = 0; i < nbits; i++) begin
      rx_data <= ch[i];
      repeat (period - 1) @(posedge clk);
      rx_bit_tick <= 1'b1;
      @(posedge clk);
      rx_bit_tick <= 1'b0;
    end
    rx_data <= 1'b1;
  endtask : send_bits
endmodule : sccc_line_peer

// file: test/scc_channel_control_tb_top.sv
// testbench: registers, clock pins, prescaler, mode, sync, receive and transmit
`timescale 1ns/10ps
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", nm, e, s); end end
module scc_channel_control_tb_top;
  import sccc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic timer_input_one = 1'b0, sys_clk_tick = 1'b0;
  logic rx_clk_from_baud = 1'b1, tx_clk_from_baud = 1'b1;
  logic baud_clk, rx_bit_tick, rx_data, tx_bit_tick, tx_data, baud_prescale_tick;
  logic rx_clock_pin_one_o, rx_clock_pin_one_oe, tx_clock_pin_one_oe;
  logic receive_enable, transmit_enable, hunt_active, rx_char_valid;
  logic [1:0] diagnostic_field, protocol_field;
  logic [7:0] first_sync_byte, second_sync_byte, rx_char, got_char;
  logic [15:0] rdata, stop_fraction_cfg;
  int n_fail = 0, total_checks = 0, cyc = 0, n_chars = 0;
  sccc_channel dut (.clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .timer_input_one,
    .sys_clk_tick, .rx_clk_from_baud, .tx_clk_from_baud, .baud_clk, .rx_clock_pin_one_o,
    .rx_clock_pin_one_oe, .tx_clock_pin_one_o(), .tx_clock_pin_one_oe, .baud_prescale_tick,
    .rx_bit_tick, .rx_data, .tx_bit_tick, .tx_data, .diagnostic_field, .protocol_field,
    .receive_enable, .transmit_enable, .hunt_active, .first_sync_byte, .second_sync_byte,
    .stop_fraction_cfg, .rx_char, .rx_char_valid);
  sccc_line_peer peer (.clk, .rx_bit_tick, .rx_data, .tx_bit_tick, .baud_clk);
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (rx_char_valid === 1'b1) begin
      got_char <= rx_char;
      n_chars <= n_chars + 1;
    end
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata & m)
  endtask : rd_chk
  task automatic t_pins;
    rd_chk(SCCC_ADR_CLOCK_PIN_OPTIONS, SCCC_ZERO16, 16'hFFFF);
    rd_chk(SCCC_ADR_CHANNEL_MODE, SCCC_ZERO16, 16'hFFFF);
    rd_chk(SCCC_ADR_SYNC_PATTERN, 16'h7E7E, 16'hFFFF);
    `CHK("first sync", 8'h7E, first_sync_byte)
    `CHK("tx_data", 1'b1, tx_data)
    `CHK("rx oe", 1'b1, rx_clock_pin_one_oe)
    `CHK("tx oe", 1'b1, tx_clock_pin_one_oe)
    wr_reg(SCCC_ADR_CLOCK_PIN_OPTIONS, 16'hFFFF);
    rd_chk(SCCC_ADR_CLOCK_PIN_OPTIONS, 16'hD000, 16'hFFFF);
    `CHK("rx oe", 1'b0, rx_clock_pin_one_oe)
    `CHK("tx oe", 1'b0, tx_clock_pin_one_oe)
    wr_reg(SCCC_ADR_CLOCK_PIN_OPTIONS, SCCC_ZERO16);
    rx_clk_from_baud <= 1'b0;
    rd_chk(SCCC_ADR_CLOCK_PIN_OPTIONS, SCCC_ZERO16, 16'hFFFF);
    `CHK("rx oe", 1'b0, rx_clock_pin_one_oe)
    `CHK("tx oe", 1'b1, tx_clock_pin_one_oe)
    @(posedge clk);
    rx_clk_from_baud <= 1'b1;
  endtask : t_pins
  task automatic t_prescale;
    int n;
    for (int b = 0; b < 3; b++) begin
      wr_reg(SCCC_ADR_CLOCK_PIN_OPTIONS, (b == 1) ? 16'h1000 : SCCC_ZERO16);
      wr_reg(SCCC_ADR_SYS_DIV, (b == 2) ? 16'h0001 : SCCC_ZERO16);
      n = 0;
      for (int i = 0; i < 32; i++) begin
        @(posedge clk);
        timer_input_one <= (b < 2) && (i % 8 == 0);
        sys_clk_tick <= (b == 2) && (i % 8 == 0);
        #1;
        n += (baud_prescale_tick === 1'b1);
      end
      `CHK("prescale ticks", (b == 0) ? 4 : 2, n)
    end
  endtask : t_prescale
  task automatic t_modes;
    logic [15:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {8'hA5, 2'b00, i[3:2], 2'b00, i[1:0]};
      wr_reg(SCCC_ADR_CHANNEL_MODE, v);
      rd_chk(SCCC_ADR_CHANNEL_MODE, v, 16'hFFFF);
      `CHK("diag", i[3:2], diagnostic_field)
      `CHK("protocol", i[1:0], protocol_field)
    end
  endtask : t_modes
  task automatic t_sync;
    wr_reg(SCCC_ADR_SYNC_PATTERN, 16'h1234);
    wr_reg(SCCC_ADR_CHANNEL_MODE, 16'h0003);
    rd_chk(SCCC_ADR_SYNC_PATTERN, 16'h1234, 16'hFFFF);
    `CHK("second sync", 8'h12, second_sync_byte)
    `CHK("first sync", 8'h34, first_sync_byte)
    wr_reg(SCCC_ADR_CHANNEL_MODE, 16'h0001);
    wr_reg(SCCC_ADR_SYNC_PATTERN, 16'h5678);
    rd_chk(SCCC_ADR_SYNC_PATTERN, 16'h5678, 16'hFFFF);
    `CHK("stop fraction", 16'h5678, stop_fraction_cfg)
    `CHK("first sync", 8'h34, first_sync_byte)
  endtask : t_sync
  task automatic wait_chars(input int k);
    int n;
    n = 0;
    while (n_chars != k && n < 40) begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask : wait_chars
  task automatic t_rx;
    wr_reg(SCCC_ADR_HUNT, SCCC_ZERO16);
    wr_reg(SCCC_ADR_CHANNEL_MODE, 16'h0008);
    rd_chk(SCCC_ADR_CHANNEL_MODE, 16'h0008, 16'hFFFF);
    `CHK("hunt", 1'b1, hunt_active)
    `CHK("rx enable", 1'b1, receive_enable)
    peer.send_bits(8'hA5, 8, 5);
    wait_chars(1);
    `CHK("rx char", 8'hA5, got_char)
    `CHK("hunt", 1'b0, hunt_active)
    peer.send_bits(8'h3C, 4, 2);
    wr_reg(SCCC_ADR_CHANNEL_MODE, SCCC_ZERO16);
    rd_chk(SCCC_ADR_STATUS, 16'h0400, 16'hFC00);
    peer.send_bits(8'hF0, 8, 3);
    wr_reg(SCCC_ADR_HUNT, SCCC_ZERO16);
    wr_reg(SCCC_ADR_CHANNEL_MODE, 16'h0008);
    peer.send_bits(8'h96, 8, 4);
    wait_chars(2);
    `CHK("rx count", 2, n_chars)
    `CHK("rx char", 8'h96, got_char)
    wr_reg(SCCC_ADR_CHANNEL_MODE, SCCC_ZERO16);
  endtask : t_rx
  task automatic t_tx;
    int lo;
    lo = 0;
    peer.tx_run <= 1'b1;
    wr_reg(SCCC_ADR_CHANNEL_MODE, 16'h0004);
    wr_reg(SCCC_ADR_STATUS, SCCC_ZERO16);
    repeat (16) begin
      @(posedge clk);
      #1;
      lo += !tx_data;
    end
    `CHK("tx sent", 1'b1, lo > 0)
    `CHK("tx enable", 1'b1, transmit_enable)
    wr_reg(SCCC_ADR_CHANNEL_MODE, SCCC_ZERO16);
    lo = 0;
    repeat (3) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      #1;
      lo += !tx_data;
    end
    `CHK("tx idle lows", 0, lo)
    `CHK("tx enable", 1'b0, transmit_enable)
    wr_reg(SCCC_ADR_CHANNEL_MODE, 16'h0024);
    peer.send_bits(8'h00, 1, 12);
    #1;
    `CHK("echo", 1'b0, tx_data)
    wr_reg(SCCC_ADR_CHANNEL_MODE, 16'h001C);
    peer.send_bits(8'h00, 8, 5);
    wait_chars(3);
    `CHK("loopback", 8'hFF, got_char)
    wr_reg(SCCC_ADR_CHANNEL_MODE, SCCC_ZERO16);
    peer.tx_run <= 1'b0;
  endtask : t_tx
  task automatic t_param;
    wr_reg(SCCC_CH0_BASE + SCCC_OFS_RX_FC, 16'h005A);
    wr_reg(SCCC_CH0_BASE + SCCC_OFS_TX_FC, 16'h00C3);
    wr_reg(SCCC_CH0_BASE + SCCC_OFS_MRBL, 16'hBEEF);
    wr_reg(SCCC_CH0_BASE + 12'h0BE, 16'h1357);
    wr_reg(SCCC_CH0_BASE + 12'h0C0, 16'hFFFF);
    wr_reg(SCCC_CH0_BASE + 12'h088, 16'h00F0);
    wr_reg(SCCC_CH0_BASE + 12'h08A, 16'h2468);
    rd_chk(SCCC_CH0_BASE + 12'h088, 16'h00F0, 16'hFFFF);
    rd_chk(SCCC_CH0_BASE + 12'h08A, 16'h2468, 16'hFFFF);
    rd_chk(SCCC_CH0_BASE + SCCC_OFS_RX_FC, 16'h005A, 16'h00FF);
    rd_chk(SCCC_CH0_BASE + SCCC_OFS_TX_FC, 16'h00C3, 16'h00FF);
    rd_chk(SCCC_CH0_BASE + SCCC_OFS_MRBL, 16'hBEEF, 16'hFFFF);
    rd_chk(SCCC_CH0_BASE + 12'h0BE, 16'h1357, 16'hFFFF);
    rd_chk(SCCC_CH0_BASE + 12'h0C0, SCCC_ZERO16, 16'hFFFF);
    rd_chk(SCCC_CH1_BASE + SCCC_OFS_RX_FC, SCCC_ZERO16, 16'hFFFF);
  endtask : t_param
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_pins;
    t_prescale;
    t_modes;
    t_sync;
    t_rx;
    t_tx;
    t_param;
    tally_and_finish;
  end
endmodule : scc_channel_control_tb_top
